// *** rtl/phyan_pkg.sv ***
// phyan_pkg: constants for the auto-negotiation register set.
// assumes 32-bit axi4-lite register access, 16-bit registers in low bits.
package phyan_pkg;
  localparam int unsigned PHYAN_ADDR_W = 8;
  localparam int unsigned PHYAN_DATA_W = 32;
  localparam int unsigned PHYAN_REG_W = 16;
  localparam int unsigned PHYAN_IDX_W = 6;
  // register indexes; byte address is index times four
  localparam logic [PHYAN_IDX_W-1:0] PHYAN_IDX_MODE_CTRL = 6'h00;
  localparam logic [PHYAN_IDX_W-1:0] PHYAN_IDX_MODE_STAT = 6'h01;
  localparam logic [PHYAN_IDX_W-1:0] PHYAN_IDX_ADV = 6'h04;
  localparam logic [PHYAN_IDX_W-1:0] PHYAN_IDX_LP_ABIL = 6'h05;
  localparam logic [PHYAN_IDX_W-1:0] PHYAN_IDX_EXPAN = 6'h06;
  localparam logic [PHYAN_IDX_W-1:0] PHYAN_IDX_NP_TX = 6'h07;
  localparam logic [PHYAN_IDX_W-1:0] PHYAN_IDX_LP_NP = 6'h08;
  localparam logic [PHYAN_IDX_W-1:0] PHYAN_IDX_IRQ_STAT = 6'h10;
  localparam logic [PHYAN_IDX_W-1:0] PHYAN_IDX_IRQ_MASK = 6'h11;
  localparam int unsigned PHYAN_IDX_LSB = 2;
  // field positions
  localparam int unsigned PHYAN_CTRL_RESTART = 9;
  localparam int unsigned PHYAN_STAT_COMPLETE = 5;
  localparam int unsigned PHYAN_LP_ASYM = 11;
  localparam int unsigned PHYAN_EXP_PDF = 4;
  localparam int unsigned PHYAN_EXP_LP_NP = 3;
  localparam int unsigned PHYAN_EXP_NP_ABLE = 2;
  localparam int unsigned PHYAN_EXP_PAGE_RX = 1;
  localparam int unsigned PHYAN_EXP_LP_AN = 0;
  localparam int unsigned PHYAN_PG_NP = 15;
  localparam int unsigned PHYAN_NP_TOGGLE = 11;
  // writable masks and reset values
  localparam logic [15:0] PHYAN_ADV_WMASK = 16'hade0 | 16'h001f;
  localparam logic [15:0] PHYAN_ADV_RESET = 16'h01e1;
  localparam logic [15:0] PHYAN_LP_WMASK = 16'h0800;
  localparam logic [15:0] PHYAN_LP_RX_MASK = 16'hefff;
  localparam logic [15:0] PHYAN_NPTX_WMASK = 16'hb7ff;
  localparam logic [15:0] PHYAN_NPTX_RESET = 16'h2001;
  localparam logic [15:0] PHYAN_ZERO16 = 16'h0000;
  // interrupt status bits
  localparam int unsigned PHYAN_IRQ_W = 3;
  localparam int unsigned PHYAN_IRQ_PAGE = 0;
  localparam int unsigned PHYAN_IRQ_FAULT = 1;
  localparam int unsigned PHYAN_IRQ_DONE = 2;
  // axi responses
  localparam logic [1:0] PHYAN_RESP_OKAY = 2'h0;
  localparam logic [1:0] PHYAN_RESP_SLVERR = 2'h2;
endpackage

// *** rtl/phyan_regs.sv ***
// phyan_regs: auto-negotiation register group of a gigabit phy behind axi4-lite.
// assumes a line-side negotiation engine feeds received pages and events,
// and takes the advertised pages and the restart pulse.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module phyan_regs (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // axi4-lite slave
  input wire logic [phyan_pkg::PHYAN_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [phyan_pkg::PHYAN_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [phyan_pkg::PHYAN_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [phyan_pkg::PHYAN_DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // line-side negotiation engine
  input wire logic rx_page_valid_in,
  input wire logic rx_page_is_next_in,
  input wire logic [phyan_pkg::PHYAN_REG_W-1:0] rx_link_code_word_in,
  input wire logic tx_page_sent_in,
  input wire logic parallel_fault_in,
  input wire logic an_complete_in,
  output logic [phyan_pkg::PHYAN_REG_W-1:0] adv_page_out,
  output logic [phyan_pkg::PHYAN_REG_W-1:0] next_page_tx_out,
  output logic an_restart_out,
  output logic irq_out
);
  import phyan_pkg::*;

  typedef struct packed {
    logic aw_have;
    logic [PHYAN_IDX_W-1:0] aw_idx;
    logic aw_bad;
    logic w_have;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    logic [15:0] adv;
    logic [15:0] lp_abil;
    logic exp_pdf;
    logic exp_lp_np;
    logic exp_page_rx;
    logic exp_lp_an;
    logic [15:0] np_tx;
    logic [15:0] lp_np;
    logic complete;
    logic done_seen;
    logic restart;
    logic [PHYAN_IRQ_W-1:0] irq_stat;
    logic [PHYAN_IRQ_W-1:0] irq_mask;
    logic irq;
  } phyan_state_s;

  phyan_state_s st_q;
  phyan_state_s st_d;

  // byte-lane merge of a 16-bit register with a writable-bit mask
  function automatic logic [15:0] phyan_merge(input logic [15:0] cur, input logic [15:0] wdat,
                                              input logic [1:0] strb, input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    phyan_merge = (cur & ~lanes) | (wdat & lanes);
  endfunction

  function automatic logic phyan_mapped(input logic [PHYAN_IDX_W-1:0] idx);
    phyan_mapped = (idx == PHYAN_IDX_MODE_CTRL) || (idx == PHYAN_IDX_MODE_STAT) ||
                   (idx == PHYAN_IDX_ADV) || (idx == PHYAN_IDX_LP_ABIL) ||
                   (idx == PHYAN_IDX_EXPAN) || (idx == PHYAN_IDX_NP_TX) ||
                   (idx == PHYAN_IDX_LP_NP) || (idx == PHYAN_IDX_IRQ_STAT) ||
                   (idx == PHYAN_IDX_IRQ_MASK);
  endfunction

  logic [PHYAN_IDX_W-1:0] rd_idx;
  logic [15:0] exp_view;
  logic [15:0] stat_view;
  logic [15:0] ctrl_view;
  logic [15:0] rd_val;
  logic do_write;
  logic do_read;
  logic [PHYAN_IRQ_W-1:0] irq_evt;
  logic [PHYAN_IRQ_W-1:0] irq_clr;
  logic [PHYAN_IRQ_W-1:0] irq_next;

  assign rd_idx = s_axi_araddr_in[PHYAN_IDX_LSB +: PHYAN_IDX_W];
  assign do_read = s_axi_arvalid_in && st_q.arready;
  assign do_write = st_q.aw_have && st_q.w_have && !st_q.bvalid;

  // expansion view, reserved bits zero, next-page ability constant one
  always_comb begin
    exp_view = PHYAN_ZERO16;
    exp_view[PHYAN_EXP_PDF] = st_q.exp_pdf;
    exp_view[PHYAN_EXP_LP_NP] = st_q.exp_lp_np;
    exp_view[PHYAN_EXP_NP_ABLE] = 1'b1;
    exp_view[PHYAN_EXP_PAGE_RX] = st_q.exp_page_rx;
    exp_view[PHYAN_EXP_LP_AN] = st_q.exp_lp_an;
    stat_view = PHYAN_ZERO16;
    stat_view[PHYAN_STAT_COMPLETE] = st_q.complete;
    ctrl_view = PHYAN_ZERO16;
    ctrl_view[PHYAN_CTRL_RESTART] = st_q.restart;
  end

  // read mux
  always_comb begin
    rd_val = PHYAN_ZERO16;
    unique case (rd_idx)
      PHYAN_IDX_MODE_CTRL: rd_val = ctrl_view;
      PHYAN_IDX_MODE_STAT: rd_val = stat_view;
      PHYAN_IDX_ADV: rd_val = st_q.adv;
      PHYAN_IDX_LP_ABIL: rd_val = st_q.lp_abil;
      PHYAN_IDX_EXPAN: rd_val = exp_view;
      PHYAN_IDX_NP_TX: rd_val = st_q.np_tx;
      PHYAN_IDX_LP_NP: rd_val = st_q.lp_np;
      PHYAN_IDX_IRQ_STAT: rd_val = {{(16-PHYAN_IRQ_W){1'b0}}, st_q.irq_stat};
      PHYAN_IDX_IRQ_MASK: rd_val = {{(16-PHYAN_IRQ_W){1'b0}}, st_q.irq_mask};
      default: rd_val = PHYAN_ZERO16;
    endcase
  end

  // interrupt events
  always_comb begin
    irq_evt = '0;
    irq_evt[PHYAN_IRQ_PAGE] = rx_page_valid_in;
    irq_evt[PHYAN_IRQ_FAULT] = parallel_fault_in;
    irq_evt[PHYAN_IRQ_DONE] = an_complete_in && !st_q.done_seen;
  end

  // write-one-clear request on the status register
  assign irq_clr = (do_write && (st_q.aw_idx == PHYAN_IDX_IRQ_STAT) && st_q.w_strb[0]) ?
                   st_q.w_data[PHYAN_IRQ_W-1:0] : '0;

  // sticky status per bit; an event in the clearing cycle wins
  for (genvar i = 0; i < PHYAN_IRQ_W; i++) begin : g_irq
    assign irq_next[i] = irq_evt[i] | (st_q.irq_stat[i] & ~irq_clr[i]);
  end

  always_comb begin
    st_d = st_q;
    // write address and data channels, taken in either order
    if (s_axi_awvalid_in && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_idx = s_axi_awaddr_in[PHYAN_IDX_LSB +: PHYAN_IDX_W];
      st_d.aw_bad = !phyan_mapped(s_axi_awaddr_in[PHYAN_IDX_LSB +: PHYAN_IDX_W]);
    end
    if (s_axi_wvalid_in && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.w_data = s_axi_wdata_in[15:0];
      st_d.w_strb = s_axi_wstrb_in[1:0];
    end
    st_d.awready = !st_d.aw_have;
    st_d.wready = !st_d.w_have;
    if (st_q.bvalid && s_axi_bready_in) begin
      st_d.bvalid = 1'b0;
    end

    // line side: restart pulse lasts one cycle
    st_d.restart = 1'b0;
    st_d.complete = an_complete_in;
    st_d.done_seen = an_complete_in;

    // toggle reads the inverse of the last sent word's toggle
    if (tx_page_sent_in) begin
      st_d.np_tx[PHYAN_NP_TOGGLE] = !st_q.np_tx[PHYAN_NP_TOGGLE];
    end

    // read clears the fault and page-received expansion bits; a new event below still sets them
    if (do_read && rd_idx == PHYAN_IDX_EXPAN) begin
      st_d.exp_pdf = 1'b0;
      st_d.exp_page_rx = 1'b0;
    end

    // register writes
    if (do_write) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready = 1'b1;
      st_d.bvalid = 1'b1;
      st_d.bresp = st_q.aw_bad ? PHYAN_RESP_SLVERR : PHYAN_RESP_OKAY;
      unique case (st_q.aw_idx)
        PHYAN_IDX_MODE_CTRL: begin
          if (st_q.w_strb[1] && st_q.w_data[PHYAN_CTRL_RESTART]) begin
            st_d.restart = 1'b1;
            st_d.np_tx[PHYAN_NP_TOGGLE] = 1'b0;
          end
        end
        PHYAN_IDX_ADV: begin
          st_d.adv = phyan_merge(st_q.adv, st_q.w_data, st_q.w_strb,
                                 PHYAN_ADV_WMASK);
        end
        PHYAN_IDX_LP_ABIL: begin
          st_d.lp_abil = phyan_merge(st_q.lp_abil, st_q.w_data, st_q.w_strb,
                                     PHYAN_LP_WMASK);
        end
        PHYAN_IDX_NP_TX: begin
          st_d.np_tx = phyan_merge(st_d.np_tx, st_q.w_data, st_q.w_strb,
                                   PHYAN_NPTX_WMASK);
        end
        PHYAN_IDX_IRQ_STAT: begin
          st_d.irq_stat = irq_next;
        end
        PHYAN_IDX_IRQ_MASK: begin
          if (st_q.w_strb[0]) begin
            st_d.irq_mask = st_q.w_data[PHYAN_IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // received pages; hardware sets win over software clears
    if (rx_page_valid_in) begin
      st_d.exp_page_rx = 1'b1;
      if (rx_page_is_next_in) begin
        st_d.lp_np = rx_link_code_word_in;
      end else begin
        st_d.lp_abil = rx_link_code_word_in & PHYAN_LP_RX_MASK;
        st_d.exp_lp_an = 1'b1;
        st_d.exp_lp_np = rx_link_code_word_in[PHYAN_PG_NP];
      end
    end
    if (parallel_fault_in) begin
      st_d.exp_pdf = 1'b1;
    end
    st_d.irq_stat = irq_next;
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);

    // read channel
    if (st_q.rvalid && s_axi_rready_in) begin
      st_d.rvalid = 1'b0;
    end
    if (do_read) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = rd_val;
      st_d.rresp = phyan_mapped(rd_idx) ? PHYAN_RESP_OKAY : PHYAN_RESP_SLVERR;
    end
    st_d.arready = !st_d.rvalid;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
      st_q.awready <= 1'b1;
      st_q.wready <= 1'b1;
      st_q.arready <= 1'b1;
      st_q.adv <= PHYAN_ADV_RESET;
      st_q.lp_abil <= PHYAN_ZERO16;
      st_q.np_tx <= PHYAN_NPTX_RESET;
      st_q.lp_np <= PHYAN_ZERO16;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready_out = st_q.awready;
  assign s_axi_wready_out = st_q.wready;
  assign s_axi_bresp_out = st_q.bresp;
  assign s_axi_bvalid_out = st_q.bvalid;
  assign s_axi_arready_out = st_q.arready;
  assign s_axi_rdata_out = {16'h0000, st_q.rdata};
  assign s_axi_rresp_out = st_q.rresp;
  assign s_axi_rvalid_out = st_q.rvalid;
  assign adv_page_out = st_q.adv;
  assign next_page_tx_out = st_q.np_tx;
  assign an_restart_out = st_q.restart;
  assign irq_out = st_q.irq;
endmodule

// *** tb/phyan_partner.sv ***
// phyan_partner: remote link partner model feeding received code words.
// assumes the bench asks for pages; word line is junk outside a page.
`timescale 1ns/10ps
module phyan_partner (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic send_in,
  input wire logic next_in,
  input wire logic ack_in,
  input wire logic [15:0] word_in,
  output logic page_valid_out,
  output logic is_next_out,
  output logic sent_out,
  output logic [15:0] word_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_valid_out <= 1'b0;
      is_next_out <= 1'b0;
      sent_out <= 1'b0;
      word_out <= 16'h0000;
    end else begin
      page_valid_out <= send_in;
      is_next_out <= next_in;
      sent_out <= ack_in;
      word_out <= send_in ? word_in : ~word_out;
    end
  end
endmodule

// *** tb/phyan_regs_assertions.sv ***
// phyan_regs_assertions: port checks of the register group.
// assumes one clock domain, bound to phyan_regs.
`timescale 1ns/10ps
module phyan_regs_assertions (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic rx_page_valid_in,
  input wire logic tx_page_sent_in,
  input wire logic [15:0] adv_page_out,
  input wire logic [15:0] next_page_tx_out,
  input wire logic an_restart_out,
  input wire logic irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_rst_val;
    $rose(reset_n_in) |-> adv_page_out == 16'h01e1 && next_page_tx_out == 16'h2001;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
  property p_adv_rsv;
    adv_page_out[14] == 1'b0 && adv_page_out[12] == 1'b0 && adv_page_out[9] == 1'b0;
  endproperty
  a_adv_rsv: assert property (p_adv_rsv) else $error("advert reserved set");
  property p_np_rsv;
    next_page_tx_out[14] == 1'b0;
  endproperty
  a_np_rsv: assert property (p_np_rsv) else $error("next page reserved set");
  property p_toggle;
    tx_page_sent_in |=> next_page_tx_out[11] != $past(next_page_tx_out[11]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flip");
  property p_restart;
    an_restart_out |=> !an_restart_out;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not a pulse");
  property p_rd_hi;
    s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read data set");
  property p_rd_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_ar_ans;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
  c_page: cover property (rx_page_valid_in ##1 irq_out);
  c_restart: cover property (an_restart_out);
  c_toggle: cover property ($rose(next_page_tx_out[11]));
endmodule
bind phyan_regs phyan_regs_assertions u_chk (.*);

// *** tb/tb_top.sv ***
// tb_top: self-checking bench for phyan_regs over axi4-lite.
// assumes phyan_pkg first; partner model drives pages and sent, the bench drives fault and complete.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
  import phyan_pkg::*;
  logic sys_clk_in = 0, reset_n_in = 0, s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
  logic s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic parallel_fault_in = 0, an_complete_in = 0, send = 0, nxt = 0, ack = 0, saw = 0;
  logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic [2:0] s_axi_awprot_in = 0, s_axi_arprot_in = 0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, rd_q, seed = 69;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, an_restart_out, irq_out;
  logic rx_page_valid_in, rx_page_is_next_in, tx_page_sent_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp_q;
  logic [15:0] rx_link_code_word_in, adv_page_out, next_page_tx_out, word = 0, d, w;
  int num_errors = 0, checked = 0, cyc = 0;
  phyan_partner peer (.clk_in(sys_clk_in), .rst_n_in(reset_n_in), .send_in(send),
    .next_in(nxt), .ack_in(ack), .word_in(word), .page_valid_out(rx_page_valid_in),
    .is_next_out(rx_page_is_next_in), .sent_out(tx_page_sent_in),
    .word_out(rx_link_code_word_in));
  phyan_regs dut (.*);
  initial begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic logic [15:0] exp_x(input logic [15:0] b, input logic pg, input logic pf);
    return {11'h0, pf, b[15], 1'b1, pg, 1'b1};
  endfunction
  task automatic stop_test();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cyc++;
    if (an_restart_out === 1'b1) saw <= 1;
    if (cyc == 4000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    bit aw, wd;
    aw = 1;
    wd = 1;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {16'h0, v};
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    while (aw || wd) begin
      @(posedge sys_clk_in);
      if (aw && s_axi_awready_out) begin aw = 0; s_axi_awvalid_in <= 0; end
      if (wd && s_axi_wready_out) begin wd = 0; s_axi_wvalid_in <= 0; end
    end
    s_axi_bready_in <= 1;
    do @(posedge sys_clk_in); while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 0;
    resp_q = s_axi_bresp_out;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    do @(posedge sys_clk_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 0;
    s_axi_rready_in <= 1;
    do @(posedge sys_clk_in); while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 0;
    rd_q = s_axi_rdata_out;
    resp_q = s_axi_rresp_out;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    `CHK("rdata", {16'h0, e}, rd_q)
    `CHK("rresp", PHYAN_RESP_OKAY, resp_q)
  endtask
  task automatic page(input logic n, input logic [15:0] v);
    word <= v;
    nxt <= n;
    send <= 1;
    @(posedge sys_clk_in);
    send <= 0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_in);
    reset_n_in <= 1;
    @(posedge sys_clk_in);
    rdc(8'h10, 16'h01e1);
    rdc(8'h14, 16'h0000);
    rdc(8'h18, 16'h0004);
    rdc(8'h1c, 16'h2001);
    rdc(8'h20, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'hffff : rnd();
      wr(8'h10, d);
      rdc(8'h10, d & 16'hadff);
      wr(8'h1c, d);
      rdc(8'h1c, d & 16'hb7ff);
    end
    ack <= 1;
    @(posedge sys_clk_in);
    ack <= 0;
    repeat (3) @(posedge sys_clk_in);
    rdc(8'h1c, (d & 16'hb7ff) | 16'h0800);
    wr(8'h00, 16'h0200);
    repeat (2) @(posedge sys_clk_in);
    `CHK("restart", 1'b1, saw)
    rdc(8'h00, 16'h0000);
    rdc(8'h1c, d & 16'hb7ff);
    wr(8'h14, 16'hffff);
    `CHK("bresp", PHYAN_RESP_OKAY, resp_q)
    rdc(8'h14, 16'h0800);
    wr(8'h3c, 16'h1234);
    `CHK("bresp", 2'h2, resp_q)
    rd(8'h3c);
    `CHK("rresp", PHYAN_RESP_SLVERR, resp_q)
    `CHK("rdata", 32'h0, rd_q)
    wr(8'h44, 16'h0001);
    w = rnd();
    page(0, w);
    `CHK("irq", 1'b1, irq_out)
    rdc(8'h14, w & 16'hefff);
    rdc(8'h18, exp_x(w, 1, 0));
    rdc(8'h18, exp_x(w, 0, 0));
    wr(8'h40, 16'h0001);
    repeat (2) @(posedge sys_clk_in);
    `CHK("irq", 1'b0, irq_out)
    wr(8'h44, 16'h0000);
    d = rnd();
    page(1, d);
    `CHK("irq", 1'b0, irq_out)
    rdc(8'h20, d);
    wr(8'h20, ~d);
    rdc(8'h20, d);
    rdc(8'h18, exp_x(w, 1, 0));
    parallel_fault_in <= 1;
    @(posedge sys_clk_in);
    parallel_fault_in <= 0;
    repeat (2) @(posedge sys_clk_in);
    rdc(8'h18, exp_x(w, 0, 1));
    rdc(8'h18, exp_x(w, 0, 0));
    rd(8'h04);
    `CHK("complete", 1'b0, rd_q[5])
    an_complete_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    rd(8'h04);
    `CHK("complete", 1'b1, rd_q[5])
    rdc(8'h40, 16'h0007);
    wr(8'h44, 16'h0004);
    @(posedge sys_clk_in);
    `CHK("irq", 1'b1, irq_out)
    wr(8'h40, 16'h0007);
    @(posedge sys_clk_in);
    `CHK("irq", 1'b0, irq_out)
    stop_test();
  end
endmodule
